/* File: mmd_memory_map_decoder.sv */
/*
 mmd_memory_map_decoder: cpu address map decode, map register, external bus drive.
 assumes cpu bus cycles are one core_clk cycle marked by cpuValid; AHB-Lite slave for
 the map, mode and config registers; data for internal reads comes from the sources.
*/
// Summary of operation
// - unclaimed addresses go external in expanded modes
// - internal wins reads; port C data ignored
// - internal writes also drive port C in expanded modes
// - strobe, direction, address valid every cycle in expanded modes; data driven on writes only
// - bootstrap: single-chip map plus boot region
// - bootstrap vectors fetched from boot region
// - test mode: expanded map, external boot vectors
// - register block moves to any 4K page
// - map register writable once in 64 cycles, except in test mode
// - map register resets to 01
// - upper nibble ram page, lower register page
// - ram overrides rom in top pages
// - registers override ram and rom
// - unused register slots read undriven bus
// - rom disabled when enable bit clear
// - single-chip mode forces rom on
// - eeprom decoded B600 to B7FF
// - eeprom off when enable bit zero
`timescale 1ns/1ns
`default_nettype none
module mmd_memory_map_decoder #(
   parameter int WINDOW_CYC = mmd_pkg::MAP_WINDOW_CYC // write-once window length
) (
   input wire logic core_clk, // 50 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [1:0] modeStrap, // mode pins, caught after reset
   input wire logic hsel, // ahb slave select
   input wire logic [7:0] haddr, // ahb byte address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size
   input wire logic hready, // ahb bus ready
   input wire logic [31:0] hwdata, // ahb write data
   output logic [31:0] hrdata, // ahb read data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   input wire logic cpuValid, // cpu bus cycle this clock
   input wire logic [15:0] cpuAddr, // cpu address
   input wire logic cpuWrite, // cpu write
   input wire logic cpuVector, // cpu vector fetch
   input wire logic [7:0] cpuWdata, // cpu write data
   input wire logic [7:0] regRdata, // register block read data
   input wire logic regSlotUsed, // addressed register slot exists
   input wire logic [7:0] ramRdata, // ram read data
   input wire logic [7:0] romRdata, // rom read data
   input wire logic [7:0] eeRdata, // eeprom read data
   input wire logic [7:0] bootRdata, // boot program read data
   input wire logic [7:0] portCIn, // port C data inputs
   output logic [7:0] cpuRdata, // data to cpu, one cycle after request
   output logic [4:0] selOneHot, // regs, ram, rom, ee, boot select
   output logic [15:0] extAddr, // external address
   output logic [7:0] portCOut, // port C data out
   output logic portCOe_n, // port C drive enable, low drives
   output logic addressStrobe, // external address strobe
   output logic extRw, // external read/write, high reads
   output logic mapLocked // map register no longer writable
);
   ////////////////////////////////////////////////////////////////////////////
   // registers and mode
   logic [7:0] map_q, map_d;
   logic [7:0] prio_q, prio_d;
   logic [7:0] cfg_q, cfg_d;
   logic [6:0] winCnt_q, winCnt_d;
   logic written_q, written_d;
   logic strapTaken_q;
   logic [15:0] fetchAddr;
   mmd_pkg::mmd_mode_e mode;
   mmd_pkg::mmd_sel_e selNow;
   mmd_dec_if dIf ();

   function automatic logic [7:0] rdSel(input logic [7:0] a, input logic [7:0] m,
         input logic [7:0] p, input logic [7:0] c, input logic l);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         mmd_pkg::ADDR_MAP: r = m;
         mmd_pkg::ADDR_PRIO: r = p;
         mmd_pkg::ADDR_CFG: r = c;
         mmd_pkg::ADDR_STAT: r = {7'h00, l};
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   assign mode = mmd_pkg::mmd_mode_e'({prio_q[mmd_pkg::PRIO_SPECIAL_MODE_BIT_BIT],
      prio_q[mmd_pkg::PRIO_MDA_BIT]});
   wire logic isExpanded = (mode == mmd_pkg::MODE_EXPANDED) || (mode == mmd_pkg::MODE_TEST);
   wire logic windowOpen = (winCnt_q < 7'(WINDOW_CYC)) && !written_q;
   wire logic testMode = (mode == mmd_pkg::MODE_TEST);

   ////////////////////////////////////////////////////////////////////////////
   // vector redirection: boot and test fetch from the BFC0 page
   always_comb begin
      fetchAddr = cpuAddr;
      if (cpuVector && (cpuAddr >= mmd_pkg::VEC_BASE)
            && ((mode == mmd_pkg::MODE_BOOT) || testMode)) begin
         fetchAddr = {mmd_pkg::BOOT_VEC_BASE[15:6], cpuAddr[5:0]};
      end
   end

   // decoder inputs; single-chip forces rom on, boot region only in bootstrap
   assign dIf.addr = fetchAddr;
   assign dIf.mapVal = map_q;
   assign dIf.rom_enable_bit = cfg_q[mmd_pkg::CFG_ROM_BIT] || (mode == mmd_pkg::MODE_SINGLE);
   assign dIf.eeprom_enable_bit = cfg_q[mmd_pkg::CFG_EE_BIT];
   assign dIf.bootOn = prio_q[mmd_pkg::PRIO_BOOT_BIT] && (mode == mmd_pkg::MODE_BOOT);
   assign dIf.extOn = isExpanded;
   assign selNow = dIf.sel;

   mmd_region_dec uDec (
      .d(dIf.dec)
   );

   ////////////////////////////////////////////////////////////////////////////
   // ahb slave: zero wait states, okay always
   logic aPend_q, aWrite_q;
   logic [7:0] aAddr_q;
   wire logic aTake = hsel && htrans[1] && hready;
   wire logic busWrMap = aPend_q && aWrite_q && (aAddr_q == mmd_pkg::ADDR_MAP);
   wire logic busWrPrio = aPend_q && aWrite_q && (aAddr_q == mmd_pkg::ADDR_PRIO);
   wire logic busWrCfg = aPend_q && aWrite_q && (aAddr_q == mmd_pkg::ADDR_CFG);
   wire logic cpuRegHit = cpuValid && (selNow == mmd_pkg::SEL_REGS);
   wire logic [5:0] cpuRegOff = fetchAddr[5:0];
   wire logic cpuWrMap = cpuRegHit && cpuWrite
      && (cpuRegOff == mmd_pkg::IDX_MAP[5:0]);
   wire logic cpuWrPrio = cpuRegHit && cpuWrite
      && (cpuRegOff == mmd_pkg::IDX_PRIO[5:0]);
   wire logic cpuWrCfg = cpuRegHit && cpuWrite
      && (cpuRegOff == mmd_pkg::IDX_CFG[5:0]);

   // address phase capture
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aPend_q <= 1'b0;
         aWrite_q <= 1'b0;
         aAddr_q <= 8'h00;
      end else if (hready) begin
         aPend_q <= aTake;
         aWrite_q <= hwrite;
         aAddr_q <= haddr;
      end
   end

   // read data registered at the address phase so it stands in the data phase
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (aTake && !hwrite) begin
         // next values, so a write landing this edge is not read back stale
         hrdata <= {24'h00_0000, rdSel(haddr, map_d, prio_d, cfg_d, !windowOpen)};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // map register write-once window; test mode lifts the limit
   always_comb begin
      map_d = map_q;
      written_d = written_q;
      if ((busWrMap || cpuWrMap) && (windowOpen || testMode)) begin
         map_d = busWrMap ? hwdata[7:0] : cpuWdata;
         written_d = !testMode;
      end
   end

   always_comb begin
      prio_d = busWrPrio ? hwdata[7:0] : (cpuWrPrio ? cpuWdata : prio_q);
      cfg_d = busWrCfg ? hwdata[7:0] : (cpuWrCfg ? cpuWdata : cfg_q);
      winCnt_d = (winCnt_q < 7'(WINDOW_CYC)) ? winCnt_q + 7'd1 : winCnt_q;
   end

   // mode strap caught on the first cycle after reset release
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         map_q <= mmd_pkg::MAP_RESET;
         written_q <= 1'b0;
         winCnt_q <= 7'd0;
         prio_q <= mmd_pkg::PRIO_RESET;
         cfg_q <= mmd_pkg::CFG_RESET;
         strapTaken_q <= 1'b0;
      end else begin
         map_q <= map_d;
         written_q <= written_d;
         winCnt_q <= winCnt_d;
         cfg_q <= cfg_d;
         strapTaken_q <= 1'b1;
         if (!strapTaken_q) begin
            prio_q <= {modeStrap == 2'b10, modeStrap[1], modeStrap[0], 5'h00};
         end else begin
            prio_q <= prio_d;
         end
      end
   end

   // lock flag from a flop, built from next state so it does not lag the window
   wire logic windowOpenNext = (winCnt_d < 7'(WINDOW_CYC)) && !written_d;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mapLocked <= 1'b0;
      end else begin
         mapLocked <= !windowOpenNext && !testMode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cpu read data select; unused register slots give the idle bus value
   logic [7:0] rdNow;
   always_comb begin
      case (selNow)
         mmd_pkg::SEL_REGS: rdNow = regSlotUsed ? regRdata : mmd_pkg::UNDRIVEN_BYTE;
         mmd_pkg::SEL_RAM: rdNow = ramRdata;
         mmd_pkg::SEL_ROM: rdNow = romRdata;
         mmd_pkg::SEL_EE: rdNow = eeRdata;
         mmd_pkg::SEL_BOOT: rdNow = bootRdata;
         mmd_pkg::SEL_EXT: rdNow = portCIn; // only external reads see port C
         default: rdNow = mmd_pkg::UNDRIVEN_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // external bus: every cycle shows up outside in expanded modes, even internal
   // ones; port C never drives on reads so external parts own the read bus
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cpuRdata <= 8'h00;
         selOneHot <= 5'h00;
         extAddr <= 16'h0000;
         portCOut <= 8'h00;
         portCOe_n <= 1'b1;
         addressStrobe <= 1'b0;
         extRw <= 1'b1;
      end else begin
         cpuRdata <= rdNow;
         selOneHot <= cpuValid ? {selNow == mmd_pkg::SEL_BOOT, selNow == mmd_pkg::SEL_EE,
            selNow == mmd_pkg::SEL_ROM, selNow == mmd_pkg::SEL_RAM,
            selNow == mmd_pkg::SEL_REGS} : 5'h00;
         addressStrobe <= cpuValid && isExpanded;
         extAddr <= isExpanded ? fetchAddr : 16'h0000;
         extRw <= !(cpuValid && isExpanded && cpuWrite);
         portCOut <= cpuWdata;
         portCOe_n <= !(cpuValid && isExpanded && cpuWrite);
      end
   end
endmodule
`default_nettype wire

/* File: mmd_pkg.sv */
/*
 memory map decoder package: region bounds, map register layout, offsets, timing counts.
 assumes a 16-bit cpu address space and an AHB-Lite register port with word registers.
*/
`default_nettype none
package mmd_pkg;
   // register indices; they are not all word aligned, so each gets a word of its own
   localparam logic [15:0] IDX_PRIO = 16'h103c;
   localparam logic [15:0] IDX_MAP = 16'h103d;
   localparam logic [15:0] IDX_CFG = 16'h103f;
   // bus byte address is four times the index; the slave decodes only the low byte
   localparam logic [7:0] ADDR_PRIO = 8'({IDX_PRIO, 2'b00});
   localparam logic [7:0] ADDR_MAP = 8'({IDX_MAP, 2'b00});
   localparam logic [7:0] ADDR_CFG = 8'({IDX_CFG, 2'b00});
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   // map register fields and reset value
   localparam int MAP_RAM_LSB = 4;
   localparam int MAP_REG_LSB = 0;
   localparam logic [7:0] MAP_RESET = 8'h01;
   // priority/mode register fields
   localparam int PRIO_BOOT_BIT = 7;
   localparam int PRIO_SPECIAL_MODE_BIT_BIT = 6;
   localparam int PRIO_MDA_BIT = 5;
   localparam logic [7:0] PRIO_RESET = 8'h00;
   // configuration register fields
   localparam int CFG_ROM_BIT = 1;
   localparam int CFG_EE_BIT = 0;
   localparam logic [7:0] CFG_RESET = 8'h03;
   // fixed regions
   localparam logic [15:0] ROM_BASE = 16'he000;
   localparam logic [15:0] EE_BASE = 16'hb600;
   localparam logic [15:0] EE_LAST = 16'hb7ff;
   localparam logic [15:0] BOOT_BASE = 16'hbf40;
   localparam logic [15:0] VEC_BASE = 16'hffc0;
   localparam logic [15:0] BOOT_VEC_BASE = 16'hbfc0;
   // write window after reset, in bus clock cycles
   localparam int MAP_WINDOW_CYC = 64;
   localparam logic [7:0] UNDRIVEN_BYTE = 8'hff;
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_EXPANDED = 2'b01,
      MODE_BOOT = 2'b10,
      MODE_TEST = 2'b11
   } mmd_mode_e;
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_REGS = 3'b001,
      SEL_RAM = 3'b010,
      SEL_ROM = 3'b011,
      SEL_EE = 3'b100,
      SEL_BOOT = 3'b101,
      SEL_EXT = 3'b110
   } mmd_sel_e;
endpackage
`default_nettype wire

/* File: mmd_dec_if.sv */
/*
 mmd_dec_if: address and enables toward the region decoder, selection back.
 assumes a single clock; carries only combinational signals.
*/
`timescale 1ns/1ns
`default_nettype none
interface mmd_dec_if;
   logic [15:0] addr;
   logic [7:0] mapVal;
   logic rom_enable_bit;
   logic eeprom_enable_bit;
   logic bootOn;
   logic extOn;
   mmd_pkg::mmd_sel_e sel;
   modport ctrl (output addr, output mapVal, output rom_enable_bit, output eeprom_enable_bit, output bootOn,
      output extOn, input sel);
   modport dec (input addr, input mapVal, input rom_enable_bit, input eeprom_enable_bit, input bootOn,
      input extOn, output sel);
endinterface
`default_nettype wire

/* File: mmd_region_dec.sv */
/*
 mmd_region_dec: pure combinational priority decode of one 16-bit address.
 assumes enables already reflect mode and configuration.
*/
`timescale 1ns/1ns
`default_nettype none
module mmd_region_dec (
   mmd_dec_if.dec d // decode request and answer
);
   wire logic [3:0] ramPage = d.mapVal[mmd_pkg::MAP_RAM_LSB +: 4];
   wire logic [3:0] regPage = d.mapVal[mmd_pkg::MAP_REG_LSB +: 4];
   // page plus low-bit checks
   wire logic hitRegs = (d.addr[15:12] == regPage) && (d.addr[11:6] == 6'h00);
   wire logic hitRam = (d.addr[15:12] == ramPage) && (d.addr[11:8] == 4'h0);
   wire logic hitRom = d.rom_enable_bit && (d.addr >= mmd_pkg::ROM_BASE);
   wire logic hitEe = d.eeprom_enable_bit && (d.addr >= mmd_pkg::EE_BASE)
      && (d.addr <= mmd_pkg::EE_LAST);
   // boot program sits only in the top of its page, not above it
   wire logic hitBoot = d.bootOn && (d.addr[15:8] == mmd_pkg::BOOT_BASE[15:8])
      && (d.addr >= mmd_pkg::BOOT_BASE);
   // fixed priority: registers over ram over the rest, external last
   always_comb begin
      if (hitRegs) begin
         d.sel = mmd_pkg::SEL_REGS;
      end else if (hitRam) begin
         d.sel = mmd_pkg::SEL_RAM;
      end else if (hitRom) begin
         d.sel = mmd_pkg::SEL_ROM;
      end else if (hitEe) begin
         d.sel = mmd_pkg::SEL_EE;
      end else if (hitBoot) begin
         d.sel = mmd_pkg::SEL_BOOT;
      end else if (d.extOn) begin
         d.sel = mmd_pkg::SEL_EXT;
      end else begin
         d.sel = mmd_pkg::SEL_NONE;
      end
   end
endmodule
`default_nettype wire

/* File: mmd_ext_model.sv */
/*
 mmd_ext_model: external memory and I/O on the multiplexed port C bus.
 assumes the decoder samples port C in the same cycle as the cpu request.
*/
`timescale 1ns/1ns
`default_nettype none
module mmd_ext_model (
   input wire logic core_clk, // bus clock
   input wire logic cpuValid, // bus cycle under way
   input wire logic cpuWrite, // write cycle
   input wire logic [15:0] cpuAddr, // address on the bus
   output logic [7:0] portCIn // data returned on port C
);
   logic [7:0] lastByte_q = 8'h00;
   ////////////////////////////////////////
   // reads answer a pattern of the address; otherwise the line floats, so never show old data
   assign portCIn = (cpuValid && !cpuWrite) ? (cpuAddr[7:0] ^ 8'h5a) : ~lastByte_q;
   always_ff @(posedge core_clk) lastByte_q <= portCIn;
endmodule
`default_nettype wire

/* File: mmd_assertions.sv */
/*
 mmd_assertions: port-level timing and decode checks on the map decoder.
 assumes modeStrap stays steady through each reset and the run after it.
*/
`timescale 1ns/1ns
`default_nettype none
module mmd_assertions #(
   parameter int WINDOW_CYC = 64 // map write window
) (
   input wire logic core_clk, // clock
   input wire logic rst_n, // sync reset, active low
   input wire logic [1:0] modeStrap, // mode pins
   input wire logic cpuValid, // cpu cycle
   input wire logic [15:0] cpuAddr, // cpu address
   input wire logic cpuWrite, // cpu write
   input wire logic cpuVector, // vector fetch
   input wire logic [7:0] cpuWdata, // cpu write data
   input wire logic [4:0] selOneHot, // region select
   input wire logic [15:0] extAddr, // external address
   input wire logic [7:0] portCOut, // port C out
   input wire logic portCOe_n, // low drives
   input wire logic addressStrobe, // strobe
   input wire logic extRw, // high reads
   input wire logic mapLocked // map closed
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   logic [7:0] cycCount_q;
   ////////////////////////////////////////
   // saturating, so a long run never wraps back into the write window
   always_ff @(posedge core_clk) begin
      if (!rst_n) cycCount_q <= 8'h00;
      else if (cycCount_q != 8'hff) cycCount_q <= cycCount_q + 8'h01;
   end
   ////////////////////////////////////////
   property p_onehot;
      $onehot0(selOneHot);
   endproperty
   a_onehot: assert property (p_onehot) else $error("two regions selected");
   property p_wrdrive;
      cpuValid && cpuWrite && modeStrap[0] |=> !portCOe_n && portCOut == $past(cpuWdata);
   endproperty
   a_wrdrive: assert property (p_wrdrive) else $error("write not driven out");
   property p_strobe;
      cpuValid && modeStrap[0] && !cpuVector |=>
         addressStrobe && extRw == !$past(cpuWrite) && extAddr == $past(cpuAddr);
   endproperty
   a_strobe: assert property (p_strobe) else $error("bus signals wrong");
   property p_rdfloat;
      cpuValid && !cpuWrite |=> portCOe_n;
   endproperty
   a_rdfloat: assert property (p_rdfloat) else $error("port driven on a read");
   property p_rom_enable_bit;
      cpuValid && modeStrap == 2'b00 && cpuAddr >= 16'he000 |=> selOneHot[2:0] != 3'b000;
   endproperty
   a_rom_enable_bit: assert property (p_rom_enable_bit) else $error("rom off in single chip");
   property p_bootvec;
      cpuValid && cpuVector && modeStrap == 2'b10 && cpuAddr >= 16'hffc0 |=> selOneHot == 5'h10;
   endproperty
   a_bootvec: assert property (p_bootvec) else $error("vector not from boot");
   property p_testvec;
      cpuValid && cpuVector && modeStrap == 2'b11 && cpuAddr >= 16'hffc0 |=>
         selOneHot == 5'h00 && extAddr == ($past(cpuAddr) & 16'hbfff);
   endproperty
   a_testvec: assert property (p_testvec) else $error("test vector wrong");
   property p_window;
      int'(cycCount_q) > WINDOW_CYC + 1 && modeStrap != 2'b11 |-> mapLocked;
   endproperty
   a_window: assert property (p_window) else $error("map open too long");
endmodule
bind mmd_memory_map_decoder mmd_assertions #(.WINDOW_CYC(WINDOW_CYC)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .modeStrap(modeStrap), .cpuValid(cpuValid),
   .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuVector(cpuVector), .cpuWdata(cpuWdata),
   .selOneHot(selOneHot), .extAddr(extAddr), .portCOut(portCOut), .portCOe_n(portCOe_n),
   .addressStrobe(addressStrobe), .extRw(extRw), .mapLocked(mapLocked));
`default_nettype wire

/* File: mmd_memory_map_decoder_bench.sv */
/*
 mmd_memory_map_decoder_bench: scenario tasks over the register bus and cpu port.
 assumes the ext model answers port C in the request cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module mmd_memory_map_decoder_bench;
   localparam int WIN = 8; // short window keeps the late-write case quick
   logic core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, regSlotUsed = 1'b1;
   logic cpuValid = 1'b0, cpuWrite = 1'b0, cpuVector = 1'b0;
   logic [1:0] modeStrap = 2'b00, htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [7:0] haddr = 8'h00, cpuWdata = 8'h00, portCIn, cpuRdata, portCOut;
   logic [15:0] cpuAddr = 16'h0000, extAddr;
   logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
   logic hreadyout, hresp, portCOe_n, addressStrobe, extRw, mapLocked;
   logic [4:0] selOneHot;
   int mismatches = 0, num_checks = 0;
   always #10 core_clk = ~core_clk;
   mmd_memory_map_decoder #(.WINDOW_CYC(WIN)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
      .modeStrap(modeStrap), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cpuValid(cpuValid), .cpuAddr(cpuAddr),
      .cpuWrite(cpuWrite), .cpuVector(cpuVector), .cpuWdata(cpuWdata), .regRdata(8'h11),
      .regSlotUsed(regSlotUsed), .ramRdata(8'h22), .romRdata(8'h33), .eeRdata(8'h44),
      .bootRdata(8'h55), .portCIn(portCIn), .cpuRdata(cpuRdata), .selOneHot(selOneHot),
      .extAddr(extAddr), .portCOut(portCOut), .portCOe_n(portCOe_n),
      .addressStrobe(addressStrobe), .extRw(extRw), .mapLocked(mapLocked));
   mmd_ext_model u_ext (.core_clk(core_clk), .cpuValid(cpuValid), .cpuWrite(cpuWrite),
      .cpuAddr(cpuAddr), .portCIn(portCIn));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // strap is held through reset, so the mode is caught on release
   task automatic rst(input logic [1:0] m);
      @(posedge core_clk);
      modeStrap <= m;
      rst_n <= 1'b0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      regSlotUsed <= 1'b1;
      @(posedge core_clk);
   endtask
   // single ahb transfer; waits on hready in both phases, data taken at the last edge
   task automatic ahb(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
   endtask
   // one cpu cycle; answer stands one cycle, looked at mid-cycle
   task automatic cpu(input logic [15:0] a, input logic w, input logic v,
         input logic [4:0] s, input logic [7:0] d);
      @(posedge core_clk);
      cpuValid <= 1'b1;
      cpuAddr <= a;
      cpuWrite <= w;
      cpuVector <= v;
      cpuWdata <= d;
      @(posedge core_clk);
      cpuValid <= 1'b0;
      @(negedge core_clk);
      chk(selOneHot, s);
      if (!w && s != 5'h00) chk(cpuRdata, d);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [4:0] s, input logic [7:0] d);
      cpu(a, 1'b0, 1'b0, s, d);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rst(2'b00);
      ahb(mmd_pkg::ADDR_MAP, 1'b0, 8'h00);
      chk(rd, 32'h0000_0001);
      chk(mapLocked, 1'b0);
      rdc(16'h00ff, 5'h02, 8'h22);
      rdc(16'h0100, 5'h00, 8'h00);
      rdc(16'h103f, 5'h01, 8'h11);
      rdc(16'h1040, 5'h00, 8'h00);
      rdc(16'hb600, 5'h08, 8'h44);
      rdc(16'hb7ff, 5'h08, 8'h44);
      rdc(16'hb800, 5'h00, 8'h00);
      rdc(16'hbf40, 5'h00, 8'h00);
   endtask
   // both pages on F000: registers over ram over rom; second write refused
   task automatic t_once();
      rst(2'b00);
      ahb(mmd_pkg::ADDR_MAP, 1'b1, 8'hff);
      ahb(mmd_pkg::ADDR_MAP, 1'b1, 8'h35);
      ahb(mmd_pkg::ADDR_MAP, 1'b0, 8'h00);
      chk(rd, 32'h0000_00ff);
      ahb(mmd_pkg::ADDR_STAT, 1'b0, 8'h00);
      chk(rd, 32'h0000_0001);
      chk(mapLocked, 1'b1);
      rdc(16'hf03f, 5'h01, 8'h11);
      rdc(16'hf040, 5'h02, 8'h22);
      rdc(16'hf100, 5'h04, 8'h33);
      rdc(16'h1000, 5'h00, 8'h00);
      @(posedge core_clk);
      regSlotUsed <= 1'b0;
      rdc(16'hf010, 5'h01, 8'hff);
   endtask
   task automatic t_late();
      rst(2'b00);
      repeat (WIN + 4) @(posedge core_clk);
      ahb(mmd_pkg::ADDR_MAP, 1'b1, 8'h55);
      ahb(8'h10, 1'b1, 8'h77);
      ahb(8'h10, 1'b0, 8'h00);
      chk(rd, 32'h0000_0000);
      chk(hresp, 1'b0);
      chk(mapLocked, 1'b1);
      ahb(mmd_pkg::ADDR_MAP, 1'b0, 8'h00);
      chk(rd, 32'h0000_0001);
   endtask
   task automatic t_cfg();
      rst(2'b01);
      ahb(mmd_pkg::ADDR_CFG, 1'b1, 8'h00);
      rdc(16'he000, 5'h00, 8'h00);
      chk(cpuRdata, 8'h5a);
      rdc(16'hb600, 5'h00, 8'h00);
      rst(2'b00);
      ahb(mmd_pkg::ADDR_CFG, 1'b1, 8'h00);
      rdc(16'he000, 5'h04, 8'h33);
   endtask
   task automatic t_exp();
      rst(2'b01);
      cpu(16'h0010, 1'b1, 1'b0, 5'h02, 8'ha5);
      chk(portCOut, 8'ha5);
      chk(portCOe_n, 1'b0);
      chk({addressStrobe, extRw, extAddr}, 18'h2_0010);
      rdc(16'h0010, 5'h02, 8'h22);
      chk({portCOe_n, extRw}, 2'b11);
      rdc(16'h4000, 5'h00, 8'h00);
      chk(cpuRdata, 8'h5a);
   endtask
   task automatic t_modes();
      rst(2'b10);
      rdc(16'hbf40, 5'h10, 8'h55);
      cpu(16'hfffe, 1'b0, 1'b1, 5'h10, 8'h55);
      rdc(16'h2000, 5'h00, 8'h00);
      chk(addressStrobe, 1'b0);
      rdc(16'hc000, 5'h00, 8'h00);
      rst(2'b11);
      cpu(16'hfffe, 1'b0, 1'b1, 5'h00, 8'h00);
      chk(extAddr, 16'hbffe);
      chk(cpuRdata, 8'ha4);
   endtask
   ////////////////////////////////////////
   initial begin
      t_reset();
      t_once();
      t_late();
      t_cfg();
      t_exp();
      t_modes();
      end_of_test();
   end
   // whole run is well under 2000 cycles; this only cuts a hang short
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end
endmodule
`default_nettype wire
